// [dsc_defs.svh]
// Purpose: Named timing and field constants for the command spacing gate
// Assumes: Command clock of 100 MHz, times held in picoseconds
// Notes:   Definitions only; included by the package, the timer and the gate
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH

// ----------------------------------------------------------------------
// Clock and counter sizing
// ----------------------------------------------------------------------
`define DSC_CK_PS 10000
`define DSC_CNT_W 6
`define DSC_NUM_BG 4
`define DSC_NUM_BANK 16
`define DSC_FAW_DEPTH 4

// ----------------------------------------------------------------------
// Page size codes
// ----------------------------------------------------------------------
`define DSC_PAGE_HALF 2'h0
`define DSC_PAGE_1K 2'h1
`define DSC_PAGE_2K 2'h2

// ----------------------------------------------------------------------
// Spacing minimums: time in ps and floor in clock cycles
// ----------------------------------------------------------------------
`define DSC_CCD_L_PS 5355
`define DSC_CCD_L_NCK 4
`define DSC_CCD_S_NCK 4
`define DSC_RRD_NCK 4
`define DSC_RRD_S_2K_PS 5300
`define DSC_RRD_S_1K_PS 3700
`define DSC_RRD_L_2K_PS 6400
`define DSC_RRD_L_1K_PS 5300
`define DSC_FAW_2K_PS 30000
`define DSC_FAW_2K_NCK 28
`define DSC_FAW_1K_PS 21000
`define DSC_FAW_1K_NCK 20
`define DSC_FAW_HALF_PS 15000
`define DSC_FAW_HALF_NCK 16
`define DSC_WTR_S_PS 2500
`define DSC_WTR_S_NCK 2
`define DSC_WTR_L_PS 7500
`define DSC_WTR_L_NCK 4
`define DSC_RTP_PS 7500
`define DSC_RTP_NCK 4
`define DSC_WR_PS 15000
`define DSC_WR_NCK 1
`define DSC_CRC_DM_PS 3750
`define DSC_CRC_DM_NCK 5
// Cycles from a write command to the start of the internal write
`define DSC_WDATA_END_NCK 8

`endif

// [dsc_pkg.sv]
// Purpose: Types and the cycle conversion shared by the spacing gate
// Assumes: dsc_defs.svh gives the clock period in ps
// Notes:   Commands are limited to activate, read, write and precharge
`include "dsc_defs.svh"

package dsc_pkg;

    // ------------------------------------------------------------------
    // Command and carrier types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DSC_ACT = 2'b00,
        DSC_RD = 2'b01,
        DSC_WR = 2'b10,
        DSC_PRE = 2'b11
    } dsc_cmd_type;

    typedef logic [`DSC_CNT_W-1:0] dsc_cnt_type;

    typedef struct packed {
        dsc_cmd_type cmd;
        logic [1:0] bg;
        logic [1:0] ba;
    } dsc_req_type;

    typedef struct packed {
        logic [1:0] page;
        logic crc_dm_en;
    } dsc_cfg_type;

    typedef struct packed {
        logic vld;
        dsc_cmd_type cmd;
        logic [1:0] bg;
        logic [1:0] ba;
    } dsc_dram_type;

    // ------------------------------------------------------------------
    // Round a time up to whole cycles, never below the cycle floor
    // ------------------------------------------------------------------
    function automatic dsc_cnt_type dsc_cyc(input int ps, input int nck);
        int c;
        c = (ps + `DSC_CK_PS - 1) / `DSC_CK_PS;
        if (c < nck) begin
            c = nck;
        end
        return c[`DSC_CNT_W-1:0];
    endfunction : dsc_cyc

endpackage : dsc_pkg

// [dsc_timer.sv]
// Purpose: Down counter that holds off a command class after an issue
// Assumes: Load value is the spacing in cycles minus one
// Notes:   A new load never shortens a hold already running
`timescale 1ns/1ps
`include "dsc_defs.svh"

module dsc_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Load request
    input wire logic ld,
    input wire dsc_pkg::dsc_cnt_type ld_val,
    // Hold status
    output logic busy
);
    import dsc_pkg::*;

    dsc_cnt_type cnt_r;
    dsc_cnt_type cnt_dec;
    dsc_cnt_type cnt_nxt;

    // Keep the larger of the remaining hold and the new one
    assign cnt_dec = (cnt_r == '0) ? '0 : cnt_r - dsc_cnt_type'(1);
    assign cnt_nxt = (ld && (ld_val > cnt_dec)) ? ld_val : cnt_dec;
    assign busy = (cnt_r != '0);

    // Counter register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule : dsc_timer

// [dsc_gate.sv]
// Purpose: Holds DDR4 commands until every spacing minimum is met
// Assumes: Command clock 100 MHz, one command request at a time
// Notes:   Spacing is counted from the cycle a command leaves the gate
//          All counts are fixed when the design is built, so another clock
//          period needs only a new period define
`timescale 1ns/1ps
`include "dsc_defs.svh"

module dsc_gate (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Static configuration
    input wire dsc_pkg::dsc_cfg_type cfg,
    // Command request from the scheduler
    input wire logic req_valid,
    input wire dsc_pkg::dsc_req_type req,
    output logic req_ack,
    // Command toward the DRAM
    output dsc_pkg::dsc_dram_type dram_cmd
);
    import dsc_pkg::*;

    // ------------------------------------------------------------------
    // Spacing counts in cycles
    // ------------------------------------------------------------------
    // Column command spacing
    localparam dsc_cnt_type CCD_L = dsc_cyc(`DSC_CCD_L_PS, `DSC_CCD_L_NCK);
    localparam dsc_cnt_type CCD_S = dsc_cnt_type'(`DSC_CCD_S_NCK);
    // Activate spacing and the rolling window
    localparam dsc_cnt_type RRD_S_2K = dsc_cyc(`DSC_RRD_S_2K_PS, `DSC_RRD_NCK);
    localparam dsc_cnt_type RRD_S_1K = dsc_cyc(`DSC_RRD_S_1K_PS, `DSC_RRD_NCK);
    localparam dsc_cnt_type RRD_L_2K = dsc_cyc(`DSC_RRD_L_2K_PS, `DSC_RRD_NCK);
    localparam dsc_cnt_type RRD_L_1K = dsc_cyc(`DSC_RRD_L_1K_PS, `DSC_RRD_NCK);
    localparam dsc_cnt_type FAW_2K = dsc_cyc(`DSC_FAW_2K_PS, `DSC_FAW_2K_NCK);
    localparam dsc_cnt_type FAW_1K = dsc_cyc(`DSC_FAW_1K_PS, `DSC_FAW_1K_NCK);
    localparam dsc_cnt_type FAW_HALF = dsc_cyc(`DSC_FAW_HALF_PS, `DSC_FAW_HALF_NCK);
    // Write turnaround, read to precharge and write recovery
    localparam dsc_cnt_type WTR_S = dsc_cyc(`DSC_WTR_S_PS, `DSC_WTR_S_NCK);
    localparam dsc_cnt_type WTR_L = dsc_cyc(`DSC_WTR_L_PS, `DSC_WTR_L_NCK);
    localparam dsc_cnt_type RTP = dsc_cyc(`DSC_RTP_PS, `DSC_RTP_NCK);
    localparam dsc_cnt_type TWR = dsc_cyc(`DSC_WR_PS, `DSC_WR_NCK);
    localparam dsc_cnt_type CRC_DM = dsc_cyc(`DSC_CRC_DM_PS, `DSC_CRC_DM_NCK);
    // Data phase of a write and the unit step
    localparam dsc_cnt_type WDATA = dsc_cnt_type'(`DSC_WDATA_END_NCK);
    localparam dsc_cnt_type ONE = dsc_cnt_type'(1);

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------
    // Output registers and the window slot pointer
    logic ack_r;
    dsc_dram_type cmd_r;
    logic [1:0] faw_ptr_r;
    // Command class and flat bank index
    wire logic is_act = (req.cmd == DSC_ACT);
    wire logic is_rd = (req.cmd == DSC_RD);
    wire logic is_wr = (req.cmd == DSC_WR);
    wire logic is_pre = (req.cmd == DSC_PRE);
    wire logic [3:0] bank = {req.bg, req.ba};
    // Page size decode; code 3 is handled as a 2KB page everywhere
    wire logic page_1k = (cfg.page == `DSC_PAGE_1K);
    wire logic page_2k = !page_1k && (cfg.page != `DSC_PAGE_HALF);

    // Page dependent spacing; unknown page codes take the 2KB figures
    wire dsc_cnt_type rrd_s = page_2k ? RRD_S_2K : RRD_S_1K;
    wire dsc_cnt_type rrd_l = page_2k ? RRD_L_2K : RRD_L_1K;
    wire dsc_cnt_type faw = page_2k ? FAW_2K :
        (page_1k ? FAW_1K : FAW_HALF);

    // Extension applies only while both CRC and mask are enabled
    wire dsc_cnt_type ext = cfg.crc_dm_en ? CRC_DM : '0;

    // Holds measured from the write command, so the data phase is added
    wire dsc_cnt_type wtr_s_ld = WDATA + WTR_S + ext - ONE;
    wire dsc_cnt_type wtr_l_ld = WDATA + WTR_L + ext - ONE;
    wire dsc_cnt_type wr_rec_ld = WDATA + TWR + ext - ONE;

    // ------------------------------------------------------------------
    // Hold timers
    // ------------------------------------------------------------------
    // Busy flags of every hold: per class, group, bank and window slot
    logic col_g_busy;
    logic act_g_busy;
    logic wtr_g_busy;
    logic [`DSC_NUM_BG-1:0] col_bg_busy;
    logic [`DSC_NUM_BG-1:0] act_bg_busy;
    logic [`DSC_NUM_BG-1:0] wtr_bg_busy;
    logic [`DSC_NUM_BANK-1:0] pre_bk_busy;
    logic [`DSC_FAW_DEPTH-1:0] faw_busy;
    logic take;

    // Any-group timers
    // Column commands to any group
    dsc_timer u_col_g (
        .clk(clk), .sys_rst(sys_rst),
        .ld(take && (is_rd || is_wr)),
        .ld_val(CCD_S - ONE),
        .busy(col_g_busy)
    );
    // Activates to any group
    dsc_timer u_act_g (
        .clk(clk), .sys_rst(sys_rst),
        .ld(take && is_act),
        .ld_val(rrd_s - ONE),
        .busy(act_g_busy)
    );
    // Reads to any group after a write
    dsc_timer u_wtr_g (
        .clk(clk), .sys_rst(sys_rst),
        .ld(take && is_wr),
        .ld_val(wtr_s_ld),
        .busy(wtr_g_busy)
    );

    // Per bank group timers
    genvar g;
    generate
        for (g = 0; g < `DSC_NUM_BG; g = g + 1) begin : g_bg
            wire logic hit = take && (req.bg == 2'(g));
            dsc_timer u_col (
                .clk(clk), .sys_rst(sys_rst),
                .ld(hit && (is_rd || is_wr)),
                .ld_val(CCD_L - ONE),
                .busy(col_bg_busy[g])
            );
            dsc_timer u_act (
                .clk(clk), .sys_rst(sys_rst),
                .ld(hit && is_act),
                .ld_val(rrd_l - ONE),
                .busy(act_bg_busy[g])
            );
            dsc_timer u_wtr (
                .clk(clk), .sys_rst(sys_rst),
                .ld(hit && is_wr),
                .ld_val(wtr_l_ld),
                .busy(wtr_bg_busy[g])
            );
        end
    endgenerate

    // Per bank precharge holds from read or write recovery
    genvar b;
    generate
        for (b = 0; b < `DSC_NUM_BANK; b = b + 1) begin : g_bank
            wire logic hit = take && (bank == 4'(b));
            dsc_timer u_pre (
                .clk(clk), .sys_rst(sys_rst),
                .ld(hit && (is_rd || is_wr)),
                .ld_val(is_wr ? wr_rec_ld : RTP - ONE),
                .busy(pre_bk_busy[b])
            );
        end
    endgenerate

    // Rolling window: one slot per remembered activate, used in turn.
    // A fifth activate must wait for the oldest slot to run out.
    genvar f;
    generate
        for (f = 0; f < `DSC_FAW_DEPTH; f = f + 1) begin : g_faw
            dsc_timer u_faw (
                .clk(clk), .sys_rst(sys_rst),
                .ld(take && is_act && (faw_ptr_r == 2'(f))),
                .ld_val(faw - ONE),
                .busy(faw_busy[f])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Issue decision: every limit checked in the same cycle
    // ------------------------------------------------------------------
    // A fifth activate waits on the slot that the pointer will reuse
    wire logic act_ok = !act_g_busy && !act_bg_busy[req.bg] &&
        !faw_busy[faw_ptr_r];
    wire logic col_ok = !col_g_busy && !col_bg_busy[req.bg];
    wire logic rd_ok = col_ok && !wtr_g_busy &&
        !wtr_bg_busy[req.bg];
    // Precharge waits on read to precharge and on write recovery
    wire logic pre_ok = !pre_bk_busy[bank];
    // Only the holds of the requested class gate the issue
    wire logic cls_ok = (is_act && act_ok) || (is_rd && rd_ok) ||
        (is_wr && col_ok) || (is_pre && pre_ok);

    // The cycle after an ack the scheduler still shows the old request
    assign take = req_valid && !ack_r && cls_ok;

    // Next command word; idle cycles carry an all-zero word
    wire dsc_dram_type cmd_nxt = take ?
        dsc_dram_type'{vld: 1'h1, cmd: req.cmd, bg: req.bg, ba: req.ba} :
        dsc_dram_type'{vld: 1'h0, cmd: DSC_ACT, bg: 2'h0, ba: 2'h0};

    // ------------------------------------------------------------------
    // Output and window pointer registers
    // ------------------------------------------------------------------
    // The pointer moves once per issued activate
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_r <= 1'h0;
            cmd_r <= '0;
            faw_ptr_r <= 2'h0;
        end else begin
            ack_r <= take;
            cmd_r <= cmd_nxt;
            faw_ptr_r <= faw_ptr_r + 2'(take && is_act);
        end
    end

    // Top outputs come straight from the registers
    assign req_ack = ack_r;
    assign dram_cmd = cmd_r;

endmodule : dsc_gate

// [dsc_gate_monitor.sv]
// Purpose: Port checker for the command spacing gate
// Assumes: 100 MHz clock, so each ns minimum except write recovery falls to its cycle floor
// Notes:   Only the latest write is aged; older ones are never tighter for a read, and a precharge is checked only against its bank
`timescale 1ns/1ps
module dsc_gate_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Watched ports
    input wire dsc_pkg::dsc_cfg_type cfg,
    input wire logic req_valid,
    input wire dsc_pkg::dsc_req_type req,
    input wire logic req_ack,
    input wire dsc_pkg::dsc_dram_type dram_cmd
);
    import dsc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [31:0] act_hist_r;
    logic [5:0] wr_age_r;
    logic [3:0] wr_bank_r;
    // Command decode and page dependent window
    wire [3:0] bank = {dram_cmd.bg, dram_cmd.ba};
    wire is_act = dram_cmd.vld && dram_cmd.cmd == DSC_ACT;
    wire is_rd = dram_cmd.vld && dram_cmd.cmd == DSC_RD;
    wire is_pre = dram_cmd.vld && dram_cmd.cmd == DSC_PRE;
    wire is_col = is_rd || (dram_cmd.vld && dram_cmd.cmd == DSC_WR);
    wire [5:0] crc_add = cfg.crc_dm_en ? 6'h5 : 6'h0;
    wire [4:0] faw = cfg.page == 2'h0 ? 5'h10
        : (cfg.page == 2'h1 ? 5'h14 : 5'h1C);
    wire [31:0] faw_mask = (32'h1 << (faw - 5'h1)) - 32'h1;
    wire [5:0] wtr_min = (dram_cmd.bg == wr_bank_r[3:2] ? 6'hC : 6'hA)
        + crc_add;
    // Activate history and age of the last write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            act_hist_r <= 32'h0;
            wr_age_r <= 6'h3F;
            wr_bank_r <= 4'h0;
        end else begin
            act_hist_r <= {act_hist_r[30:0], is_act};
            wr_age_r <= (dram_cmd.vld && dram_cmd.cmd == DSC_WR) ? 6'h1
                : wr_age_r + {5'h0, wr_age_r != 6'h3F};
            if (dram_cmd.vld && dram_cmd.cmd == DSC_WR) begin
                wr_bank_r <= bank;
            end
        end
    end
    property p_pair; req_ack == dram_cmd.vld; endproperty
    a_pair: assert property (p_pair)
        else $error("ack and command pulse differ");
    property p_pulse; req_ack |=> !req_ack; endproperty
    a_pulse: assert property (p_pulse)
        else $error("ack stood longer than one cycle");
    property p_cause; req_ack |-> $past(req_valid); endproperty
    a_cause: assert property (p_cause)
        else $error("ack without request");
    property p_copy;
        req_ack |-> dram_cmd.cmd == $past(req.cmd)
            && bank == $past({req.bg, req.ba});
    endproperty
    a_copy: assert property (p_copy)
        else $error("issued command differs from request");
    property p_col; is_col |=> (!is_col) [*3]; endproperty
    a_col: assert property (p_col)
        else $error("column commands too close");
    property p_act; is_act |=> (!is_act) [*3]; endproperty
    a_act: assert property (p_act)
        else $error("activates too close");
    property p_faw; is_act |-> $countones(act_hist_r & faw_mask) < 4;
    endproperty
    a_faw: assert property (p_faw)
        else $error("fifth activate inside window");
    property p_wtr; is_rd |-> wr_age_r >= wtr_min; endproperty
    a_wtr: assert property (p_wtr)
        else $error("read too soon after write");
    property p_wr;
        is_pre && bank == wr_bank_r |-> wr_age_r >= 6'hA + crc_add;
    endproperty
    a_wr: assert property (p_wr)
        else $error("precharge inside write recovery");
    property p_rtp;
        is_pre |-> !($past(is_rd) && $past(bank) == bank)
            && !($past(is_rd, 2) && $past(bank, 2) == bank)
            && !($past(is_rd, 3) && $past(bank, 3) == bank);
    endproperty
    a_rtp: assert property (p_rtp)
        else $error("precharge too soon after read");
endmodule : dsc_gate_monitor

bind dsc_gate dsc_gate_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
    .cfg(cfg), .req_valid(req_valid), .req(req), .req_ack(req_ack),
    .dram_cmd(dram_cmd));

// [dsc_dram_model.sv]
// Purpose: Device side that counts commands arriving too close
// Assumes: Figures at 100 MHz, where the cycle floors dominate
// Notes:   Window and write checks are left to the port checker
`timescale 1ns/1ps
module dsc_dram_model (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Command pins
    input wire dsc_pkg::dsc_dram_type dram_cmd,
    // Spacing faults seen
    output logic [7:0] viol_cnt
);
    import dsc_pkg::*;
    logic [5:0] col_age_r;
    logic [5:0] act_age_r;
    logic [5:0] rd_age_r [16];
    wire [3:0] bank = {dram_cmd.bg, dram_cmd.ba};
    wire is_act = dram_cmd.vld && dram_cmd.cmd == DSC_ACT;
    wire is_rd = dram_cmd.vld && dram_cmd.cmd == DSC_RD;
    wire is_col = is_rd || (dram_cmd.vld && dram_cmd.cmd == DSC_WR);
    wire is_pre = dram_cmd.vld && dram_cmd.cmd == DSC_PRE;
    // A fault on any class counts once per command
    wire fault = (is_col && col_age_r < 6'h4)
        || (is_act && act_age_r < 6'h4)
        || (is_pre && rd_age_r[bank] < 6'h4);
    // Ages saturate so a quiet device never wraps into a false fault
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            viol_cnt <= 8'h0;
            col_age_r <= 6'h3F;
            act_age_r <= 6'h3F;
        end else begin
            viol_cnt <= viol_cnt + {7'h0, fault};
            col_age_r <= is_col ? 6'h1 : col_age_r + {5'h0, col_age_r != 6'h3F};
            act_age_r <= is_act ? 6'h1 : act_age_r + {5'h0, act_age_r != 6'h3F};
        end
        for (int i = 0; i < 16; i++) begin
            rd_age_r[i] <= sys_rst ? 6'h3F : (is_rd && bank == i) ? 6'h1
                : rd_age_r[i] + {5'h0, rd_age_r[i] != 6'h3F};
        end
    end
endmodule : dsc_dram_model

// [dsc_gate_tb.sv]
// Purpose: Self-checking bench for the command spacing gate
// Assumes: 100 MHz clock; gaps counted between command pulses
// Notes:   Each scenario starts from its own reset and configuration
`timescale 1ns/1ps
`define DSC_CHK(nm, exp, got) begin checks_done++; \
    if ((got) !== (exp)) begin err_total++; \
    $display("[ERR] %s exp=%0d got=%0d", nm, exp, got); end end
module dsc_gate_tb;
    import dsc_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    dsc_cfg_type cfg = '0;
    logic req_valid = 1'b0;
    dsc_req_type req = '0;
    logic req_ack;
    dsc_dram_type dram_cmd;
    logic [7:0] viol_cnt;
    int cyc = 0;
    int err_total = 0;
    int checks_done = 0;
    int t [6];
    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    dsc_gate DUT (.clk(clk), .sys_rst(sys_rst), .cfg(cfg),
        .req_valid(req_valid), .req(req), .req_ack(req_ack),
        .dram_cmd(dram_cmd));
    dsc_dram_model far_end (.clk(clk), .sys_rst(sys_rst),
        .dram_cmd(dram_cmd), .viol_cnt(viol_cnt));
    task automatic report_and_stop();
        if (err_total == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // Reset with a new configuration; first request two cycles after release
    // The last command is counted by the far end one edge after it shows
    task automatic do_reset(input logic [1:0] page, input logic crc);
        req_valid <= 1'b0;
        @(posedge clk);
        `DSC_CHK("far_end_faults", 0, viol_cnt)
        sys_rst <= 1'b1;
        cfg <= '{page: page, crc_dm_en: crc};
        repeat (2) @(posedge clk);
        `DSC_CHK("reset_ack", 0, req_ack)
        `DSC_CHK("reset_cmd", 0, dram_cmd)
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : do_reset
    // Hold a request until acked; valid stays up for the next one
    task automatic issue(input dsc_cmd_type c, input logic [3:0] b,
        output int at);
        int n;
        n = 0;
        req_valid <= 1'b1;
        req <= '{cmd: c, bg: b[3:2], ba: b[1:0]};
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (req_ack !== 1'b1 && n < 100);
        at = cyc;
        `DSC_CHK("ack_wait", 1'b1, req_ack)
        if (req_ack !== 1'b1) report_and_stop();
        `DSC_CHK("issued_cmd", c, dram_cmd.cmd)
        `DSC_CHK("issued_valid", 1'b1, dram_cmd.vld)
        `DSC_CHK("issued_bank", b, {dram_cmd.bg, dram_cmd.ba})
        @(posedge clk);
    endtask : issue
    task automatic sc_column();
        do_reset(2'h2, 1'b0);
        issue(DSC_RD, 4'h0, t[0]);
        issue(DSC_RD, 4'h1, t[1]);
        issue(DSC_WR, 4'h4, t[2]);
        `DSC_CHK("col_same_grp_gap", 4, t[1] - t[0])
        `DSC_CHK("col_other_grp_gap", 4, t[2] - t[1])
    endtask : sc_column
    task automatic sc_faw();
        int faw [4] = '{16, 20, 28, 28};
        // Page code 3 must run with the 2KB figures
        for (int p = 0; p < 4; p++) begin
            do_reset(p[1:0], 1'b0);
            for (int i = 0; i < 5; i++) begin
                issue(DSC_ACT, 4'(i < 2 ? i : (i - 1) * 4), t[i]);
            end
            `DSC_CHK("act_same_grp_gap", 4, t[1] - t[0])
            `DSC_CHK("act_other_grp_gap", 4, t[2] - t[1])
            `DSC_CHK("fifth_act_span", faw[p], t[4] - t[0])
        end
    endtask : sc_faw
    task automatic sc_turn();
        for (int c = 0; c < 2; c++) begin
            do_reset(2'h1, c[0]);
            issue(DSC_WR, 4'h0, t[0]);
            issue(DSC_RD, 4'h4, t[1]);
            issue(DSC_WR, 4'h8, t[2]);
            issue(DSC_RD, 4'h9, t[3]);
            issue(DSC_WR, 4'hC, t[4]);
            issue(DSC_PRE, 4'hC, t[5]);
            `DSC_CHK("wtr_other_gap", 10 + 5 * c, t[1] - t[0])
            `DSC_CHK("wtr_same_gap", 12 + 5 * c, t[3] - t[2])
            `DSC_CHK("wr_recovery_gap", 10 + 5 * c, t[5] - t[4])
        end
    endtask : sc_turn
    task automatic sc_rtp();
        do_reset(2'h0, 1'b0);
        issue(DSC_RD, 4'h1, t[0]);
        issue(DSC_PRE, 4'h4, t[1]);
        issue(DSC_PRE, 4'h1, t[2]);
        `DSC_CHK("pre_other_bank_gap", 2, t[1] - t[0])
        `DSC_CHK("rtp_gap", 4, t[2] - t[0])
    endtask : sc_rtp
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        sc_column();
        sc_faw();
        sc_turn();
        sc_rtp();
        do_reset(2'h0, 1'b0);
        report_and_stop();
    end
endmodule : dsc_gate_tb
